// File: logic/rcsc_pkg.sv
// constants, types and carriers of the receive status and collision register group
package rcsc_pkg;

  // register bus geometry
  localparam int unsigned RCSC_ADDR_W = 8;
  localparam int unsigned RCSC_DATA_W = 8;

  // register offsets
  localparam logic [7:0] RCSC_LINK_STATUS_ADDR = 8'h0b;
  localparam logic [7:0] RCSC_RX_BIT_CONTROL_ADDR = 8'h0c;
  localparam logic [7:0] RCSC_RX_COLLISION_INFO_ADDR = 8'h0d;

  // link_status field positions
  localparam int unsigned RCSC_CIPHER_ACTIVE_BIT = 5;
  localparam int unsigned RCSC_LINK_STATE_LSB = 0;

  // rx_bit_control field positions
  localparam int unsigned RCSC_KEEP_BITS_BIT = 7;
  localparam int unsigned RCSC_FIRST_BIT_POS_LSB = 4;
  localparam int unsigned RCSC_COLL_INTEG_BIT = 3;
  localparam int unsigned RCSC_LAST_BITS_LSB = 0;

  // rx_collision_info field positions
  localparam int unsigned RCSC_COLL_POS_VALID_BIT = 7;
  localparam int unsigned RCSC_COLL_POS_LSB = 0;

  // reset values
  localparam logic [7:0] RCSC_RX_BIT_CONTROL_RESET = 8'h00;
  localparam logic RCSC_CIPHER_RESET = 1'b0;

  // collisions at or beyond this position are out of the reportable range
  localparam logic [7:0] RCSC_COLL_POS_LIMIT = 8'h40;
  // saturation value of the receive position counter
  localparam logic [7:0] RCSC_POS_COUNT_MAX = 8'hff;

  // transceiver state machine codes
  typedef enum logic [2:0] {
    RCSC_ST_IDLE = 3'b000,
    RCSC_ST_TRANSMIT_WAIT = 3'b001,
    RCSC_ST_TRANSMITTING = 3'b011,
    RCSC_ST_RECEIVE_WAIT = 3'b101,
    RCSC_ST_WAIT_DATA = 3'b110,
    RCSC_ST_RECEIVING = 3'b111
  } rcsc_link_state_t;

  // one decoded bit from the receive decoder
  typedef struct packed {
    logic valid;
    logic data;
    logic collision;
  } rcsc_rx_bit_t;

  // one assembled byte towards the fifo
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rcsc_rx_byte_t;

  // state of the bit packer
  typedef struct packed {
    logic [7:0] buffer;
    logic [2:0] pos;
    logic filled;
    rcsc_rx_byte_t out;
  } rcsc_pack_state_t;

  // state of the register group
  typedef struct packed {
    rcsc_link_state_t link_state;
    logic cipher_active;
    logic keep_bits_after_collision;
    logic [2:0] first_bit_position;
    logic collision_as_integrity_error;
    logic [2:0] last_byte_valid_bits;
    logic collision_position_valid;
    logic [6:0] collision_position;
    logic collision_seen;
    logic [7:0] pos_count;
    logic collision_flag;
    logic integrity_error_flag;
    logic [7:0] rdata;
  } rcsc_regs_state_t;

endpackage

// File: logic/rcsc_bit_packer.sv
// packs received bits into bytes starting at a selectable bit position
`timescale 1ns/1ps
module rcsc_bit_packer import rcsc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic start,
  input wire logic [2:0] align,
  input wire logic flush,
  // bit in, byte out
  input wire rcsc_rx_bit_t bit_in,
  output rcsc_rx_byte_t byte_out,
  output logic [2:0] fill
);

  rcsc_pack_state_t state_reg;
  rcsc_pack_state_t state_next;

  // place each bit, emit on bit 7, flush a partial byte at frame end
  always_comb begin
    state_next = state_reg;
    state_next.out.valid = 1'b0;
    if (start) begin
      state_next.buffer = 8'h00;
      state_next.pos = align;
      state_next.filled = 1'b0;
    end else if (bit_in.valid) begin
      state_next.buffer[state_reg.pos] = bit_in.data;
      if (state_reg.pos == 3'h7) begin
        // spill into position 0 of the next byte
        state_next.out.valid = 1'b1;
        state_next.out.data = state_next.buffer;
        state_next.buffer = 8'h00;
        state_next.pos = 3'h0;
        state_next.filled = 1'b0;
      end else begin
        state_next.pos = state_reg.pos + 3'h1;
        state_next.filled = 1'b1;
      end
    end else if (flush && state_reg.filled) begin
      state_next.out.valid = 1'b1;
      state_next.out.data = state_reg.buffer;
      state_next.filled = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign byte_out = state_reg.out;
  // zero here means the last byte was completed
  assign fill = state_reg.pos;

endmodule // rcsc_bit_packer

// File: logic/rcsc_regs.sv
// receive status, bit control and collision position register group
`timescale 1ns/1ps
module rcsc_regs import rcsc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [RCSC_ADDR_W-1:0] reg_addr,
  input wire logic [RCSC_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [RCSC_DATA_W-1:0] reg_rdata,
  // command events from the command sequencer
  input wire logic cmd_transceive,
  input wire logic cmd_receive,
  input wire logic cmd_idle,
  input wire logic authenticate_done,
  // transmitter events
  input wire logic tx_begin,
  input wire logic tx_end,
  // receiver events
  input wire logic rx_ready,
  input wire logic rx_sof,
  input wire rcsc_rx_bit_t rx_bit,
  input wire logic rx_frame_end,
  input wire logic rx_integrity_error,
  // assembled data towards the fifo
  output rcsc_rx_byte_t rx_byte,
  // status and control towards the rest of the transceiver
  output rcsc_link_state_t link_state,
  output logic cipher_active,
  output logic bit_oriented,
  output logic collision_flag,
  output logic integrity_error_flag
);

  rcsc_regs_state_t state_reg;
  rcsc_regs_state_t state_next;

  logic wr_status;
  logic wr_bit_control;
  logic reception_start;
  logic bit_taken;
  logic frame_done;
  logic bit_collides;
  logic first_collision;
  rcsc_rx_bit_t stored_bit;
  logic [2:0] packer_fill;

  // address decode of the write strobe
  always_comb begin
    wr_status = 1'b0;
    wr_bit_control = 1'b0;
    if (reg_write && reg_addr == RCSC_LINK_STATUS_ADDR) begin
      wr_status = 1'b1;
    end else if (reg_write && reg_addr == RCSC_RX_BIT_CONTROL_ADDR) begin
      wr_bit_control = 1'b1;
    end
  end

  // a reception begins with a receive command or the receive phase of a transceive
  assign reception_start = cmd_receive ||
    (state_reg.link_state == RCSC_ST_RECEIVE_WAIT && rx_ready && !cmd_idle);

  // bits only count while the receiver is inside a frame
  assign bit_taken = rx_bit.valid && state_reg.link_state == RCSC_ST_RECEIVING;
  assign frame_done = rx_frame_end && state_reg.link_state == RCSC_ST_RECEIVING;
  assign bit_collides = bit_taken && rx_bit.collision;
  assign first_collision = bit_collides && !state_reg.collision_seen;

  // bits after the first collision become zero unless software keeps them
  always_comb begin
    stored_bit = rx_bit;
    stored_bit.valid = bit_taken;
    if (state_reg.collision_seen && !state_reg.keep_bits_after_collision) begin
      stored_bit.data = 1'b0;
    end
  end

  // valid bits of the final byte; a bit arriving with the end marker is counted too
  function automatic logic [2:0] last_bits_at_end(input logic bit_now, input logic [2:0] fill);
    last_bits_at_end = bit_now ? fill + 3'h1 : fill;
  endfunction

  // next state of the whole register group
  always_comb begin
    state_next = state_reg;

    // transceiver state machine; an idle command aborts from anywhere
    if (cmd_idle) begin
      state_next.link_state = RCSC_ST_IDLE;
    end else begin
      case (state_reg.link_state)
        RCSC_ST_IDLE: begin
          if (cmd_transceive) begin
            state_next.link_state = RCSC_ST_TRANSMIT_WAIT;
          end else if (cmd_receive) begin
            state_next.link_state = RCSC_ST_RECEIVE_WAIT;
          end
        end
        RCSC_ST_TRANSMIT_WAIT: begin
          if (tx_begin) begin
            state_next.link_state = RCSC_ST_TRANSMITTING;
          end
        end
        RCSC_ST_TRANSMITTING: begin
          if (tx_end) begin
            state_next.link_state = RCSC_ST_RECEIVE_WAIT;
          end
        end
        RCSC_ST_RECEIVE_WAIT: begin
          if (rx_ready) begin
            state_next.link_state = RCSC_ST_WAIT_DATA;
          end
        end
        RCSC_ST_WAIT_DATA: begin
          if (rx_sof) begin
            state_next.link_state = RCSC_ST_RECEIVING;
          end
        end
        RCSC_ST_RECEIVING: begin
          if (rx_frame_end) begin
            state_next.link_state = RCSC_ST_IDLE;
          end
        end
        default: begin
          // unused codes 010 and 100 never persist
          state_next.link_state = RCSC_ST_IDLE;
        end
      endcase
    end

    // cipher: software may only clear, authentication sets, and the set wins
    if (wr_status && !reg_wdata[RCSC_CIPHER_ACTIVE_BIT]) begin
      state_next.cipher_active = 1'b0;
    end
    if (authenticate_done) begin
      state_next.cipher_active = 1'b1;
    end

    // receiver control written by software
    if (wr_bit_control) begin
      state_next.keep_bits_after_collision = reg_wdata[RCSC_KEEP_BITS_BIT];
      state_next.first_bit_position = reg_wdata[RCSC_FIRST_BIT_POS_LSB +: 3];
      state_next.collision_as_integrity_error = reg_wdata[RCSC_COLL_INTEG_BIT];
      state_next.last_byte_valid_bits = reg_wdata[RCSC_LAST_BITS_LSB +: 3];
    end

    // start of reception clears stale results and seeds the position counter
    if (reception_start) begin
      state_next.last_byte_valid_bits = 3'h0;
      state_next.collision_position_valid = 1'b0;
      state_next.collision_position = 7'h00;
      state_next.collision_seen = 1'b0;
      state_next.collision_flag = 1'b0;
      state_next.integrity_error_flag = 1'b0;
      // counting starts at the aligned storage position
      state_next.pos_count = {5'h00, state_reg.first_bit_position};
    end

    // position counter walks over data bits only, saturating far past range
    if (bit_taken && state_reg.pos_count != RCSC_POS_COUNT_MAX) begin
      state_next.pos_count = state_reg.pos_count + 8'h01;
    end

    // only the first collision of a frame is recorded
    if (first_collision) begin
      state_next.collision_seen = 1'b1;
      if (state_reg.pos_count < RCSC_COLL_POS_LIMIT) begin
        state_next.collision_position_valid = 1'b1;
        state_next.collision_position = state_reg.pos_count[6:0];
      end
    end

    // error flags: hardware sets, a later reception start clears
    if (bit_collides) begin
      state_next.collision_flag = 1'b1;
      if (state_reg.collision_as_integrity_error) begin
        state_next.integrity_error_flag = 1'b1;
      end
    end
    if (rx_integrity_error && state_reg.link_state == RCSC_ST_RECEIVING) begin
      state_next.integrity_error_flag = 1'b1;
    end

    // decoder result wins over a software write in the same cycle
    if (frame_done && state_reg.first_bit_position != 3'h0) begin
      state_next.last_byte_valid_bits = last_bits_at_end(stored_bit.valid, packer_fill);
    end

    // read data stand in the cycle after the strobe only; unmapped reads zero
    state_next.rdata = 8'h00;
    if (reg_read && reg_addr == RCSC_LINK_STATUS_ADDR) begin
      state_next.rdata[RCSC_CIPHER_ACTIVE_BIT] = state_reg.cipher_active;
      state_next.rdata[RCSC_LINK_STATE_LSB +: 3] = state_reg.link_state;
    end else if (reg_read && reg_addr == RCSC_RX_BIT_CONTROL_ADDR) begin
      state_next.rdata[RCSC_KEEP_BITS_BIT] = state_reg.keep_bits_after_collision;
      state_next.rdata[RCSC_FIRST_BIT_POS_LSB +: 3] = state_reg.first_bit_position;
      state_next.rdata[RCSC_COLL_INTEG_BIT] = state_reg.collision_as_integrity_error;
      state_next.rdata[RCSC_LAST_BITS_LSB +: 3] = state_reg.last_byte_valid_bits;
    end else if (reg_read && reg_addr == RCSC_RX_COLLISION_INFO_ADDR) begin
      state_next.rdata[RCSC_COLL_POS_VALID_BIT] = state_reg.collision_position_valid;
      state_next.rdata[RCSC_COLL_POS_LSB +: 7] = state_reg.collision_position;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.link_state <= RCSC_ST_IDLE;
      state_reg.cipher_active <= RCSC_CIPHER_RESET;
      state_reg.keep_bits_after_collision <= RCSC_RX_BIT_CONTROL_RESET[RCSC_KEEP_BITS_BIT];
      state_reg.first_bit_position <= RCSC_RX_BIT_CONTROL_RESET[RCSC_FIRST_BIT_POS_LSB +: 3];
      state_reg.collision_as_integrity_error <= RCSC_RX_BIT_CONTROL_RESET[RCSC_COLL_INTEG_BIT];
      state_reg.last_byte_valid_bits <= RCSC_RX_BIT_CONTROL_RESET[RCSC_LAST_BITS_LSB +: 3];
    end else begin
      state_reg <= state_next;
    end
  end

  // byte assembly; alignment zero gives plain byte-oriented packing
  rcsc_bit_packer u_packer (
    .clk(clk),
    .reset(reset),
    .start(reception_start),
    .align(state_reg.first_bit_position),
    .flush(frame_done),
    .bit_in(stored_bit),
    .byte_out(rx_byte),
    .fill(packer_fill)
  );

  // outputs straight from the state register
  assign reg_rdata = state_reg.rdata;
  assign link_state = state_reg.link_state;
  assign cipher_active = state_reg.cipher_active;
  assign bit_oriented = state_reg.first_bit_position != 3'h0;
  assign collision_flag = state_reg.collision_flag;
  assign integrity_error_flag = state_reg.integrity_error_flag;

endmodule // rcsc_regs

// File: testbench/rcsc_regs_sva.sv
// checker of the receive status and collision register group
`timescale 1ns/1ps
module rcsc_regs_sva import rcsc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [RCSC_ADDR_W-1:0] reg_addr,
  input wire logic [RCSC_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [RCSC_DATA_W-1:0] reg_rdata,
  // events
  input wire logic cmd_receive,
  input wire logic cmd_idle,
  input wire logic authenticate_done,
  input wire rcsc_rx_bit_t rx_bit,
  // status
  input wire rcsc_link_state_t link_state,
  input wire logic cipher_active,
  input wire logic bit_oriented,
  input wire logic collision_flag,
  input wire logic integrity_error_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // alignment field of a write, kept apart so $past sees a plain signal
  logic [2:0] align_w;
  assign align_w = reg_wdata[6:4];
  // reception start out of idle
  sequence s_start;
    cmd_receive && !cmd_idle && link_state == RCSC_ST_IDLE;
  endsequence
  // collided bit taken while receiving
  sequence s_coll_bit;
    link_state == RCSC_ST_RECEIVING && rx_bit.valid && rx_bit.collision && !cmd_idle;
  endsequence
  property p_rdata_quiet;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  property p_status_read;
    reg_read && reg_addr == RCSC_LINK_STATUS_ADDR
      |=> reg_rdata == {2'b00, $past(cipher_active), 2'b00, $past(link_state)};
  endproperty
  property p_cipher_set;
    $rose(cipher_active) |-> $past(authenticate_done);
  endproperty
  property p_cipher_clear;
    reg_write && reg_addr == RCSC_LINK_STATUS_ADDR && !reg_wdata[5] && !authenticate_done
      |=> !cipher_active;
  endproperty
  property p_no_code;
    link_state != 3'b100;
  endproperty
  property p_abort;
    cmd_idle |=> link_state == RCSC_ST_IDLE;
  endproperty
  property p_align_mode;
    reg_write && reg_addr == RCSC_RX_BIT_CONTROL_ADDR |=> bit_oriented == ($past(align_w) != 0);
  endproperty
  property p_coll_sets;
    s_coll_bit |=> collision_flag;
  endproperty
  property p_start_clears;
    s_start |=> !collision_flag && !integrity_error_flag;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data not idle");
  a_status_read: assert property (p_status_read) else $error("status read");
  a_cipher_set: assert property (p_cipher_set) else $error("cipher set");
  a_cipher_clear: assert property (p_cipher_clear) else $error("cipher clear");
  a_no_code: assert property (p_no_code) else $error("unused state");
  a_abort: assert property (p_abort) else $error("abort");
  a_align_mode: assert property (p_align_mode) else $error("bit mode");
  a_coll_sets: assert property (p_coll_sets) else $error("collision flag");
  a_start_clears: assert property (p_start_clears) else $error("start clear");
endmodule // rcsc_regs_sva
bind rcsc_regs rcsc_regs_sva u_sva (
  .clk(clk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .cmd_receive(cmd_receive),
  .cmd_idle(cmd_idle),
  .authenticate_done(authenticate_done),
  .rx_bit(rx_bit),
  .link_state(link_state),
  .cipher_active(cipher_active),
  .bit_oriented(bit_oriented),
  .collision_flag(collision_flag),
  .integrity_error_flag(integrity_error_flag)
);

// File: testbench/rcsc_card_model.sv
// contactless card model feeding decoded bits to the receiver
`timescale 1ns/1ps
module rcsc_card_model import rcsc_pkg::*; (
  // clock
  input wire logic clk,
  // decoded frame towards the receiver
  output logic rx_sof,
  output rcsc_rx_bit_t rx_bit,
  output logic rx_frame_end
);
  initial begin
    rx_sof = 1'b0;
    rx_bit = '0;
    rx_frame_end = 1'b0;
  end
  // one frame lsb first; gap slows the card, idle data flips so no stale value
  task automatic send(input logic [71:0] d, input int n, input int coll, input int gap);
    @(posedge clk) rx_sof <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) rx_sof <= 1'b0;
      rx_bit <= '{1'b1, d[i], i == coll};
      if (gap > 0) begin
        @(posedge clk) rx_bit <= '{1'b0, ~d[i], 1'b0};
        repeat (gap - 1) @(posedge clk);
      end
    end
    @(posedge clk) rx_bit <= '{1'b0, ~rx_bit.data, 1'b0};
    rx_frame_end <= 1'b1;
    @(posedge clk) rx_frame_end <= 1'b0;
  endtask
endmodule // rcsc_card_model

// File: testbench/rx_status_collision_regs_tb_top.sv
// self-checking bench of the receive status and collision register group
`timescale 1ns/1ps
module rx_status_collision_regs_tb_top import rcsc_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [6:0] evs = 7'h00;
  logic rx_integrity_error = 1'b0;
  logic rx_sof, rx_frame_end, cipher_active, bit_oriented, collision_flag, integrity_error_flag;
  rcsc_rx_bit_t rx_bit;
  rcsc_rx_byte_t rx_byte;
  rcsc_link_state_t link_state;
  logic [7:0] got[$];
  int fails = 0;
  int samples_checked = 0;
  // clock at 200 MHz
  always #2.5 clk = ~clk;
  rcsc_regs u_dut (
    .clk(clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .cmd_transceive(evs[6]),
    .cmd_receive(evs[5]),
    .cmd_idle(evs[4]),
    .authenticate_done(evs[3]),
    .tx_begin(evs[2]),
    .tx_end(evs[1]),
    .rx_ready(evs[0]),
    .rx_sof(rx_sof),
    .rx_bit(rx_bit),
    .rx_frame_end(rx_frame_end),
    .rx_integrity_error(rx_integrity_error),
    .rx_byte(rx_byte),
    .link_state(link_state),
    .cipher_active(cipher_active),
    .bit_oriented(bit_oriented),
    .collision_flag(collision_flag),
    .integrity_error_flag(integrity_error_flag)
  );
  rcsc_card_model u_card (
    .clk(clk),
    .rx_sof(rx_sof),
    .rx_bit(rx_bit),
    .rx_frame_end(rx_frame_end)
  );
  // collect every byte handed towards the fifo
  always @(posedge clk) if (rx_byte.valid === 1'b1) got.push_back(rx_byte.data);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_write <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_read <= 1'b0;
    #1 check(what, reg_rdata, exp);
  endtask
  // one-cycle event pulse, then let the state land
  task automatic ev(input logic [6:0] v);
    @(posedge clk) evs <= v;
    @(posedge clk) evs <= 7'h00;
    #1;
  endtask
  task automatic t_reset;
    rdc("status", 8'h0b, 8'h00);
    rdc("ctrl", 8'h0c, 8'h00);
    rdc("coll", 8'h0d, 8'h00);
    wr(8'h0d, 8'hff);
    rdc("coll ro", 8'h0d, 8'h00);
    rdc("unmapped", 8'h0e, 8'h00);
  endtask
  task automatic t_walk;
    ev(7'h40);
    check("transmit_wait_state", 8'(link_state), 8'h01);
    ev(7'h04);
    check("tx", 8'(link_state), 8'h03);
    ev(7'h02);
    check("receive_wait_state", 8'(link_state), 8'h05);
    // a parity error outside a frame is not counted
    @(posedge clk) rx_integrity_error <= 1'b1;
    @(posedge clk) rx_integrity_error <= 1'b0;
    #1 check("integ ignored", 8'(integrity_error_flag), 8'h00);
    ev(7'h01);
    rdc("wait data", 8'h0b, 8'h06);
    ev(7'h10);
    check("abort", 8'(link_state), 8'h00);
  endtask
  task automatic t_cipher;
    ev(7'h08);
    rdc("cipher on", 8'h0b, 8'h20);
    check("cipher pin", 8'(cipher_active), 8'h01);
    wr(8'h0b, 8'h20);
    rdc("cipher kept", 8'h0b, 8'h20);
    wr(8'h0b, 8'h00);
    rdc("cipher off", 8'h0b, 8'h00);
    check("cipher pin off", 8'(cipher_active), 8'h00);
  endtask
  // aligned frame, collision on 4th bit, later bits zeroed
  task automatic t_align;
    wr(8'h0c, 8'h40);
    #1 check("bit mode", 8'(bit_oriented), 8'h01);
    ev(7'h20);
    ev(7'h01);
    got.delete();
    fork
      u_card.send(72'h1fd, 9, 3, 2);
      begin
        repeat (4) @(posedge clk);
        #1 check("receiving", 8'(link_state), 8'h07);
      end
    join
    repeat (3) @(posedge clk);
    check("bytes", 8'(got.size()), 8'h02);
    check("byte0", got[0], 8'hd0);
    check("byte1", got[1], 8'h00);
    check("coll flag", 8'(collision_flag), 8'h01);
    check("integ off", 8'(integrity_error_flag), 8'h00);
    check("idle", 8'(link_state), 8'h00);
    rdc("coll pos", 8'h0d, 8'h87);
    rdc("last bits", 8'h0c, 8'h45);
  endtask
  // byte mode, values kept, collision as integrity error
  task automatic t_keep;
    wr(8'h0c, 8'h88);
    ev(7'h20);
    check("coll clr", 8'(collision_flag), 8'h00);
    rdc("coll clr", 8'h0d, 8'h00);
    ev(7'h01);
    got.delete();
    u_card.send(72'hff, 8, 2, 0);
    repeat (3) @(posedge clk);
    check("kept", got[0], 8'hff);
    check("integ", 8'(integrity_error_flag), 8'h01);
    check("byte mode", 8'(bit_oriented), 8'h00);
    rdc("coll pos", 8'h0d, 8'h82);
    rdc("no last bits", 8'h0c, 8'h88);
  endtask
  // last reportable bit and first one beyond the range
  task automatic t_range;
    logic [7:0] exp[2];
    exp = '{8'hbf, 8'h00};
    wr(8'h0c, 8'h80);
    for (int k = 0; k < 2; k++) begin
      ev(7'h20);
      ev(7'h01);
      fork
        u_card.send(72'h0, 72, 63 + k, 0);
        // a parity error inside the second frame must be counted
        if (k == 1) begin
          repeat (10) @(posedge clk);
          rx_integrity_error <= 1'b1;
          @(posedge clk) rx_integrity_error <= 1'b0;
        end
      join
      repeat (3) @(posedge clk);
      rdc("range", 8'h0d, exp[k]);
      check("flag", 8'(collision_flag), 8'h01);
      check("integ pulse", 8'(integrity_error_flag), 8'(k));
    end
    // receive phase of a transceive clears the stale collision flag
    ev(7'h40);
    ev(7'h04);
    ev(7'h02);
    check("flag kept", 8'(collision_flag), 8'h01);
    ev(7'h01);
    check("flag cleared", 8'(collision_flag), 8'h00);
    ev(7'h10);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_walk();
    t_cipher();
    t_align();
    t_keep();
    t_range();
    test_done();
  end
endmodule // rx_status_collision_regs_tb_top
